// ===== rtl/pwr_cfg.svh
// constants for the power-on and brownout control block
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH
`define ADDR_W         8
`define DATA_W         8
`define CTRL_OFS       8'h00
`define STAT_OFS       8'h01
`define CTRL_PWR_BIT   7
`define CTRL_SEL_BIT   3
`define CTRL_RSTEN_BIT 2
`define CTRL_FIE_BIT   1
`define CTRL_RIE_BIT   0
`define STAT_FALL_BIT  1
`define STAT_RISE_BIT  0
`define CTRL_RSVD      8'h70
`define STAT_RSVD      8'hfc
`define CLK_PERIOD_NS  40
`define FILTER_NS      100
`define FILTER_CYCLES  ((`FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLT_W          4
`define DELAY_CYCLES   131072
`define DELAY_W        18
`endif

// ===== rtl/pwr_pkg.sv
// types for the power-on and brownout control block
`include "pwr_cfg.svh"
package pwr_pkg;
    // reset sequencing phases
    typedef enum logic [1:0] {ph_hold, ph_count, ph_run} phase_type;
    // detector control fields
    typedef struct packed {
        logic power_on;
        logic sel;
        logic reset_en;
        logic fall_ie;
        logic rise_ie;
    } ctrl_type;
    // supply level comparator outputs, high while supply is below the level
    typedef struct packed {
        logic below_reset;
        logic below_int_hi;
        logic below_int_lo;
    } cmp_type;
    // register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } bus_type;
    // whole state of the block
    typedef struct packed {
        phase_type          phase;
        logic [`DELAY_W-1:0] delay_cnt;
        logic [`FLT_W-1:0]   flt_cnt;
        logic               pin_filt;
        cmp_type            s1;
        cmp_type            s2;
        logic               below_prev;
        ctrl_type           ctrl;
        logic               fall_flag;
        logic               rise_flag;
        logic               fall_arm;
        logic               rise_arm;
        logic [`DATA_W-1:0]  rdata;
        logic               int_n;
        logic               brn_n;
        logic               irq;
        logic               ovf;
        logic               in_reset;
    } state_type;
endpackage

// ===== rtl/power_on_and_brownout_control.sv
// power-on reset delay, clear pin filter and brownout detector control
// Notes on behaviour
// - clear pin low holds counter and chip
// - delay counter releases reset after 131072 cycles
// - clear pin glitches under 100 ns ignored
// - brownout functions start disabled after power-up
// - enabled brownout drives reset low, holds counter
// - brownout reset persists until delay completes
// - on recovery count 131072 cycles then release
// - trip level select picks interrupt trip level
// - supply fall: interrupt line low, fall flag set
// - fall with fall enable raises line zero request
// - supply rise returns interrupt line high
// - rise with rise enable sets flag and request
// - flags clear by writing 0 after reading 1
// - detector off means no reset, flags, interrupts
// - brownout reset acts only with enable set
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_cfg.svh"
module power_on_and_brownout_control #(
    parameter int DELAY_CYCLES = `DELAY_CYCLES   // power-up delay length
) (
    // clock and power-on reset
    input  wire logic                clk,
    input  wire logic                rst,
    // pins and analog comparators
    input  wire logic                external_clear_pin_n,
    input  wire pwr_pkg::cmp_type    cmp,
    // register port
    input  wire pwr_pkg::bus_type    bus,
    output logic [`DATA_W-1:0]       rdata,
    // reset and interrupt outputs
    output logic                     internal_reset,
    output logic                     delay_overflow_pulse,
    output logic                     brownout_reset_n,
    output logic                     brownout_interrupt_n,
    output logic                     external_interrupt_line_zero
);
    import pwr_pkg::*;

    // the counter must hold the delay and count at least two cycles
    if (DELAY_CYCLES < 2 || DELAY_CYCLES > (1 << `DELAY_W)) begin : g_chk
        $error("DELAY_CYCLES out of range for the delay counter");
    end

    // the filter counter must be wide enough to reach the last cycle of the window
    if (`FILTER_CYCLES < 1 || `FILTER_CYCLES > (1 << `FLT_W)) begin : g_flt_chk
        $error("filter window does not fit the filter counter");
    end

    localparam logic [`DELAY_W-1:0] DELAY_LAST = `DELAY_W'(DELAY_CYCLES - 1);
    localparam logic [`FLT_W-1:0]   FLT_LAST   = `FLT_W'(`FILTER_CYCLES - 1);

    state_type q;               // registered state
    state_type n;               // next state
    logic      brn_now;         // brownout reset condition, from registered state
    logic      below_i;         // supply below selected interrupt level
    logic      fall_ev;         // supply just fell below interrupt level
    logic      rise_ev;         // supply just rose above interrupt level
    logic      fall_clr;        // legal software clear of the fall flag
    logic      rise_clr;        // legal software clear of the rise flag
    logic      stat_wr;         // write to the status register
    logic      stat_rd;         // read of the status register

    // reads return reserved bits as ones
    function automatic logic [`DATA_W-1:0] read_mux(input state_type s,
                                                   input logic [`ADDR_W-1:0] a);
        logic [`DATA_W-1:0] v;
        v = '0;
        if (a == `CTRL_OFS) begin
            v = `CTRL_RSVD;
            v[`CTRL_PWR_BIT]   = s.ctrl.power_on;
            v[`CTRL_SEL_BIT]   = s.ctrl.sel;
            v[`CTRL_RSTEN_BIT] = s.ctrl.reset_en;
            v[`CTRL_FIE_BIT]   = s.ctrl.fall_ie;
            v[`CTRL_RIE_BIT]   = s.ctrl.rise_ie;
        end else if (a == `STAT_OFS) begin
            v = `STAT_RSVD;
            v[`STAT_FALL_BIT] = s.fall_flag;
            v[`STAT_RISE_BIT] = s.rise_flag;
        end
        return v;
    endfunction

    // level events decoded from registered state so every edge is seen once; bus strobes decoded straight from the port
    always_comb begin
        brn_now  = q.ctrl.power_on & q.ctrl.reset_en & q.s2.below_reset;
        below_i  = q.ctrl.power_on &
                   (q.ctrl.sel ? q.s2.below_int_lo : q.s2.below_int_hi);
        fall_ev  = below_i & ~q.below_prev;
        rise_ev  = q.ctrl.power_on & ~below_i & q.below_prev;
        stat_wr  = bus.wr & (bus.addr == `STAT_OFS);
        stat_rd  = bus.rd & (bus.addr == `STAT_OFS);
        fall_clr = stat_wr & ~bus.wdata[`STAT_FALL_BIT] & q.fall_arm;
        rise_clr = stat_wr & ~bus.wdata[`STAT_RISE_BIT] & q.rise_arm;
    end

    // next-state logic for the whole block
    always_comb begin
        n     = q;
        n.ovf = 1'b0;
        n.irq = 1'b0;
        // two-stage synchronisers; stage one feeds only stage two
        n.s1 = cmp;
        n.s2 = q.s1;
        // clear pin filter: a new level must persist for the whole window
        if (external_clear_pin_n != q.pin_filt) begin
            if (q.flt_cnt == FLT_LAST) begin
                n.pin_filt = external_clear_pin_n;
                n.flt_cnt  = '0;
            end else begin
                n.flt_cnt = q.flt_cnt + 1'b1;
            end
        end else begin
            n.flt_cnt = '0;
        end
        // delay counter; brownout keeps it in reset so reset cannot end early
        if (!q.pin_filt || brn_now) begin
            n.phase     = ph_hold;
            n.delay_cnt = '0;
        end else begin
            case (q.phase)
                ph_hold: begin
                    n.phase = ph_count;
                end
                ph_count: begin
                    if (q.delay_cnt == DELAY_LAST) begin
                        n.phase = ph_run;
                        n.ovf   = 1'b1;
                    end else begin
                        n.delay_cnt = q.delay_cnt + 1'b1;
                    end
                end
                default: begin
                    n.phase = ph_run;
                end
            endcase
        end
        n.in_reset = (n.phase != ph_run);
        n.brn_n    = ~brn_now;
        // register reads; a flag read as one arms its clear
        if (bus.rd) begin
            n.rdata = read_mux(q, bus.addr);
        end
        if (stat_rd) begin
            n.fall_arm = q.fall_flag;
            n.rise_arm = q.rise_flag;
        end
        // register writes
        if (bus.wr && bus.addr == `CTRL_OFS) begin
            n.ctrl.power_on = bus.wdata[`CTRL_PWR_BIT];
            n.ctrl.sel      = bus.wdata[`CTRL_SEL_BIT];
            n.ctrl.reset_en = bus.wdata[`CTRL_RSTEN_BIT];
            n.ctrl.fall_ie  = bus.wdata[`CTRL_FIE_BIT];
            n.ctrl.rise_ie  = bus.wdata[`CTRL_RIE_BIT];
        end else if (stat_wr) begin
            // writing one leaves a flag set; a clear needs a prior read of one, and any status write drops both arms
            if (fall_clr) begin
                n.fall_flag = 1'b0;
            end
            if (rise_clr) begin
                n.rise_flag = 1'b0;
            end
            n.fall_arm = 1'b0;
            n.rise_arm = 1'b0;
        end
        // level monitor; sets come after clears so a set wins
        n.below_prev = below_i;
        n.int_n      = ~below_i;
        if (fall_ev) begin
            n.fall_flag = 1'b1;
            n.irq       = q.ctrl.fall_ie;
        end
        if (rise_ev && q.ctrl.rise_ie) begin
            n.rise_flag = 1'b1;
            n.irq       = 1'b1;
        end
        // the clear pin resets the control register, both flags and their clear arms
        if (!q.pin_filt) begin
            n.ctrl      = '0;
            n.fall_flag = 1'b0;
            n.rise_flag = 1'b0;
            n.fall_arm  = 1'b0;
            n.rise_arm  = 1'b0;
        end
    end

    // state register; power-up leaves all functions in standby
    always_ff @(posedge clk) begin
        if (rst) begin
            q            <= '0;
            q.phase      <= ph_hold;
            q.int_n      <= 1'b1;
            q.brn_n      <= 1'b1;
            q.in_reset   <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // outputs straight from the state register
    assign rdata                        = q.rdata;
    assign internal_reset               = q.in_reset;
    assign delay_overflow_pulse         = q.ovf;
    assign brownout_reset_n             = q.brn_n;
    assign brownout_interrupt_n         = q.int_n;
    assign external_interrupt_line_zero = q.irq;

    // checks: last counted cycle and the release that follows it
    sequence last_count_s;
        q.phase == ph_count && q.delay_cnt == DELAY_LAST && q.pin_filt && !brn_now;
    endsequence
    sequence release_s;
        !internal_reset && delay_overflow_pulse;
    endsequence

    clear_pin_hold_a: assert property (@(posedge clk) disable iff (rst)
        !q.pin_filt |=> internal_reset && q.delay_cnt == '0 && q.ctrl == '0)
        else $error("clear pin did not hold the chip in reset");

    delay_release_a: assert property (@(posedge clk) disable iff (rst)
        last_count_s |=> release_s)
        else $error("reset not released on counter overflow");

    pin_filter_a: assert property (@(posedge clk) disable iff (rst)
        $changed(q.pin_filt) |-> $past(external_clear_pin_n) == q.pin_filt
            && $past(external_clear_pin_n, 2) == q.pin_filt
            && $past(external_clear_pin_n, 3) == q.pin_filt)
        else $error("clear pin level accepted before the filter window");

    standby_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !q.ctrl.power_on |=> brownout_reset_n && brownout_interrupt_n
            && !external_interrupt_line_zero)
        else $error("detector in standby produced an event");

    brownout_hold_a: assert property (@(posedge clk) disable iff (rst)
        brn_now |=> !brownout_reset_n && internal_reset && q.delay_cnt == '0)
        else $error("brownout did not reset the delay counter");

    fall_event_a: assert property (@(posedge clk) disable iff (rst)
        fall_ev && q.pin_filt |=> q.fall_flag && !brownout_interrupt_n
            && external_interrupt_line_zero == $past(q.ctrl.fall_ie))
        else $error("fall event not flagged as required");

    rise_event_a: assert property (@(posedge clk) disable iff (rst)
        rise_ev && q.ctrl.rise_ie && q.pin_filt |=> q.rise_flag
            && external_interrupt_line_zero && brownout_interrupt_n)
        else $error("rise event not flagged as required");

    flag_clear_a: assert property (@(posedge clk) disable iff (rst)
        $fell(q.fall_flag) && $past(q.pin_filt) |-> $past(fall_clr))
        else $error("fall flag cleared without a legal clear");

    sync_delay_a: assert property (@(posedge clk) disable iff (rst)
        ##2 q.s2 == $past(cmp, 2))
        else $error("comparator synchroniser depth wrong");

    // checks: standby, trip levels, flag persistence and the delay phases
    sequence held_three_s;
        internal_reset [*3];
    endsequence

    power_up_standby_a: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> q.ctrl == '0 && internal_reset
            && brownout_reset_n && brownout_interrupt_n)
        else $error("functions not in standby after power-up");

    level_high_a: assert property (@(posedge clk) disable iff (rst)
        q.ctrl.power_on && !q.ctrl.sel
            |=> brownout_interrupt_n == !$past(q.s2.below_int_hi))
        else $error("interrupt line did not follow the high trip level");

    level_low_a: assert property (@(posedge clk) disable iff (rst)
        q.ctrl.power_on && q.ctrl.sel
            |=> brownout_interrupt_n == !$past(q.s2.below_int_lo))
        else $error("interrupt line did not follow the low trip level");

    fall_sticky_a: assert property (@(posedge clk) disable iff (rst)
        q.fall_flag && !fall_clr && q.pin_filt
            |=> q.fall_flag)
        else $error("fall flag lost without a legal clear");

    rise_sticky_a: assert property (@(posedge clk) disable iff (rst)
        q.rise_flag && !rise_clr && q.pin_filt
            |=> q.rise_flag)
        else $error("rise flag lost without a legal clear");

    rise_quiet_a: assert property (@(posedge clk) disable iff (rst)
        rise_ev && !q.ctrl.rise_ie && !rise_clr && q.pin_filt
            |=> !external_interrupt_line_zero && q.rise_flag == $past(q.rise_flag))
        else $error("rise without its enable raised a flag or request");

    irq_source_a: assert property (@(posedge clk) disable iff (rst)
        external_interrupt_line_zero
            |-> $past(fall_ev) || $past(rise_ev))
        else $error("line zero request without a level event");

    reset_disabled_a: assert property (@(posedge clk) disable iff (rst)
        !q.ctrl.reset_en
            |=> brownout_reset_n)
        else $error("brownout reset driven while disabled");

    rise_clear_a: assert property (@(posedge clk) disable iff (rst)
        $fell(q.rise_flag) && $past(q.pin_filt)
            |-> $past(rise_clr))
        else $error("rise flag cleared without a legal clear");

    ovf_single_a: assert property (@(posedge clk) disable iff (rst)
        delay_overflow_pulse
            |=> !delay_overflow_pulse)
        else $error("overflow pulse longer than one cycle");

    run_stays_a: assert property (@(posedge clk) disable iff (rst)
        !internal_reset && q.pin_filt && !brn_now
            |=> !internal_reset)
        else $error("internal reset returned without a cause");

    recount_a: assert property (@(posedge clk) disable iff (rst)
        q.phase == ph_hold && q.pin_filt && !brn_now
            |=> q.phase == ph_count && q.delay_cnt == '0)
        else $error("delay count did not restart from zero");

    filter_steady_a: assert property (@(posedge clk) disable iff (rst)
        external_clear_pin_n == q.pin_filt
            |=> q.flt_cnt == '0 && $stable(q.pin_filt))
        else $error("clear pin filter moved on a steady pin");

    standby_flags_a: assert property (@(posedge clk) disable iff (rst)
        !q.ctrl.power_on
            |=> !$rose(q.fall_flag) && !$rose(q.rise_flag))
        else $error("flag set while the detector was off");

    brownout_persist_a: assert property (@(posedge clk) disable iff (rst)
        $fell(brownout_reset_n)
            |-> held_three_s)
        else $error("brownout reset ended before the delay count");

endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the power-on and brownout control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import pwr_pkg::*;
    localparam int DLY = 8;       // shortened power-up delay keeps the run short
    localparam int TMO = 20000;   // cycle ceiling for the whole run
    logic       clk;              // system clock
    logic       rst;              // power-on reset
    logic       pin_n;            // external clear pin, active low
    cmp_type    cmp;              // comparator levels
    bus_type    bus;              // register port request
    logic [7:0] rdata;            // read data
    logic       int_rst;          // internal reset
    logic       ovf;              // delay overflow pulse
    logic       bo_rst_n;         // brownout reset, active low
    logic       bo_int_n;         // brownout interrupt, active low
    logic       irq;              // line zero request
    int         error_cnt;        // mismatches
    int         samples_checked;  // comparisons
    int         cyc;              // cycles since start
    int         irq_cnt;          // line zero pulses seen
    int         ovf_cnt;          // overflow pulses seen
    logic [7:0] d;                // scratch read value
    logic [7:0] v;                // scratch random value
    int         n;                // scratch cycle count

    power_on_and_brownout_control #(.DELAY_CYCLES(DLY)) power_on_and_brownout_control_i (
        .clk(clk), .rst(rst), .external_clear_pin_n(pin_n), .cmp(cmp), .bus(bus),
        .rdata(rdata), .internal_reset(int_rst), .delay_overflow_pulse(ovf),
        .brownout_reset_n(bo_rst_n), .brownout_interrupt_n(bo_int_n),
        .external_interrupt_line_zero(irq));

    // free-running clock, 40 ns period
    initial clk = 1'b0;
    always #20 clk = ~clk;

    // pulse counters and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (ovf === 1'b1) ovf_cnt <= ovf_cnt + 1;
        if (cyc == TMO) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] timeout expected 0 seen 1");
            conclude();
        end
    end

    // reserved control bits read as one
    function automatic logic [7:0] ctrl_exp(input logic [7:0] w);
        return (w & 8'h8f) | 8'h70;
    endfunction

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one-cycle write strobe, then idle
    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        @(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
        @(posedge clk) bus <= '0;
    endtask

    // one-cycle read strobe; data stand in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk) bus <= '0;
        #1 q = rdata;
    endtask

    // comparator change seen three edges later through the synchroniser
    task automatic step(input cmp_type c, input logic en, input logic ei);
        @(posedge clk) cmp <= c;
        repeat (3) @(posedge clk);
        #1 chk("int_n", {7'h0, bo_int_n}, {7'h0, en});
        chk("irq", {7'h0, irq}, {7'h0, ei});
        @(posedge clk);
        #1 chk("irq_len", {7'h0, irq}, 8'h00);
    endtask

    // bounded wait for the reset release, which must coincide with overflow
    task automatic await_release(output int cnt);
        cnt = 0;
        while (int_rst !== 1'b0 && cnt < 1000) begin
            @(posedge clk);
            #1 cnt++;
        end
        chk("ovf_at_release", {7'h0, ovf}, 8'h01);
        chk("delay_len", {7'h0, cnt >= DLY && cnt <= DLY + 6}, 8'h01);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        pin_n = 1'b0;
        cmp = '0;
        bus = '0;
        error_cnt = 0;
        samples_checked = 0;
        v = $urandom(55361);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // clear pin low, then a glitch shorter than the filter window
        repeat (20) @(posedge clk);
        pin_n <= 1'b1;
        repeat (2) @(posedge clk);
        pin_n <= 1'b0;
        repeat (DLY + 20) @(posedge clk);
        #1 chk("held_reset", {7'h0, int_rst}, 8'h01);
        chk("no_ovf", ovf_cnt[7:0], 8'h00);
        @(posedge clk) pin_n <= 1'b1;
        await_release(n);
        $display("test power_up done");
        rd(8'h00, d);
        chk("ctrl_reset", d, 8'h70);
        rd(8'h01, d);
        chk("stat_reset", d, 8'hfc);
        wr(8'h05, 8'hff);
        rd(8'h05, d);
        chk("unmapped", d, 8'h00);
        // detector off: random levels and settings must stay silent
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom()) & 8'h7f;
            wr(8'h00, v);
            @(posedge clk) cmp <= cmp_type'(3'($urandom()));
            repeat (4) @(posedge clk);
            #1 chk("off_int_n", {7'h0, bo_int_n}, 8'h01);
            chk("off_rst_n", {7'h0, bo_rst_n}, 8'h01);
            rd(8'h00, d);
            chk("ctrl_rw", d, ctrl_exp(v));
            rd(8'h01, d);
            chk("off_stat", d, 8'hfc);
        end
        chk("off_irq", irq_cnt[7:0], 8'h00);
        $display("test detector_off done");
        // power up, settle, write status zeros with no prior read (so nothing clears), enable fall interrupt
        @(posedge clk) cmp <= '0;
        wr(8'h00, 8'h80);
        repeat (250) @(posedge clk);
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h82);
        step(3'h2, 1'b0, 1'b1);
        step(3'h0, 1'b1, 1'b0);
        rd(8'h01, d);
        chk("fall_only", d, 8'hfe);
        wr(8'h01, 8'h03);
        wr(8'h01, 8'h00);
        rd(8'h01, d);
        chk("clear_unread", d, 8'hfe);
        wr(8'h01, 8'h00);
        rd(8'h01, d);
        chk("clear_read", d, 8'hfc);
        wr(8'h00, 8'h81);
        step(3'h2, 1'b0, 1'b0);
        step(3'h0, 1'b1, 1'b1);
        rd(8'h01, d);
        chk("both_flags", d, 8'hff);
        // other trip level selected
        wr(8'h00, 8'h89);
        step(3'h2, 1'b1, 1'b0);
        step(3'h3, 1'b0, 1'b0);
        step(3'h2, 1'b1, 1'b1);
        step(3'h0, 1'b1, 1'b0);
        $display("test interrupt_levels done");
        // brownout with reset disabled, then enabled
        wr(8'h00, 8'h80);
        step(3'h4, 1'b1, 1'b0);
        chk("rst_n_disabled", {7'h0, bo_rst_n}, 8'h01);
        chk("no_chip_reset", {7'h0, int_rst}, 8'h00);
        step(3'h0, 1'b1, 1'b0);
        wr(8'h00, 8'h84);
        step(3'h4, 1'b1, 1'b0);
        chk("rst_n_low", {7'h0, bo_rst_n}, 8'h00);
        repeat (30) @(posedge clk);
        #1 chk("persist", {7'h0, int_rst}, 8'h01);
        chk("persist_n", {7'h0, bo_rst_n}, 8'h00);
        @(posedge clk) cmp <= '0;
        await_release(n);
        $display("test brownout done");
        // shut detection down: enables first, one cycle, then power
        wr(8'h00, 8'h80);
        @(posedge clk);
        wr(8'h00, 8'h00);
        rd(8'h00, d);
        chk("ctrl_off", d, 8'h70);
        chk("shut_int_n", {7'h0, bo_int_n}, 8'h01);
        chk("shut_rst_n", {7'h0, bo_rst_n}, 8'h01);
        $display("test shutdown done");
        // second power-on reset in mid-run
        @(posedge clk) rst <= 1'b1;
        repeat (16) @(posedge clk);
        #1 chk("rst_held", {7'h0, int_rst}, 8'h01);
        @(posedge clk) rst <= 1'b0;
        await_release(n);
        rd(8'h00, d);
        chk("ctrl_again", d, 8'h70);
        $display("test second_reset done");
        conclude();
    end
endmodule
`default_nettype wire
